// ### src/rtc_ctl_core.sv
// Control, interrupt and power logic of the real-time clock.
// Assumes i_sys_rst is the power-on reset and the crystal, mains and
// system-voltage sense arrive as asynchronous pin levels.
`timescale 1ns/100ps
`include "rtc_ctl_map.svh"

module rtc_ctl_core
  import rtc_ctl_pkg::*;
#(
  parameter int ALARM_DLY_32K_CYC = `ALARM_DLY_32K_CYC,
  parameter int PSENSE_DLY_CYC = `PSENSE_DLY_CYC
) (
  // System clock and power-on reset
  input wire logic i_clock,
  input wire logic i_sys_rst,
  // Serial link
  input wire logic i_spi_sck,
  input wire logic i_spi_ce,
  input wire logic i_spi_mosi,
  output logic o_spi_miso,
  output logic o_spi_miso_oe,
  // Timebase and supply sense pins
  input wire logic i_crystal_timebase,
  input wire logic i_mains_line,
  input wire logic i_sys_volt_ok,
  // Time counters, same clock
  input wire logic i_alarm_match,
  input wire logic i_minute_tick,
  input wire logic i_hour_tick,
  input wire logic i_day_tick,
  output logic o_second_tick,
  // Outputs
  output logic o_square_out,
  output logic o_supply_enable_out,
  output logic o_irq_n_drive_low,
  output logic o_host_reset_out_n_drive_low
);

  reg_byte_t timebase_and_output_control;
  reg_byte_t interrupt_and_power_control;
  reg_byte_t status;
  reg_byte_t rd_data;
  pwr_state_e pwr_state;

  // Serial port on the link clock
  logic xfer_toggle, xfer_write;
  logic [5:0] xfer_addr;
  reg_byte_t xfer_data;

  rtc_serial_port u_port (
    .i_spi_sck(i_spi_sck),
    .i_spi_ce(i_spi_ce),
    .i_spi_mosi(i_spi_mosi),
    .o_spi_miso(o_spi_miso),
    .o_spi_miso_oe(o_spi_miso_oe),
    .i_sys_rst(i_sys_rst),
    .i_rd_data(rd_data),
    .o_xfer_toggle(xfer_toggle),
    .o_xfer_write(xfer_write),
    .o_xfer_addr(xfer_addr),
    .o_xfer_data(xfer_data)
  );

  // Two-flop synchronisers: crystal, mains, voltage, chip-select, link toggle
  logic [4:0] sync_raw, sync_a, sync_b, sync_d;
  assign sync_raw = {xfer_toggle, i_spi_ce, i_sys_volt_ok, i_mains_line, i_crystal_timebase};

  genvar gs;
  generate
    for (gs = 0; gs < 5; gs++) begin : g_sync
      always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
          sync_a[gs] <= 1'b0;
          sync_b[gs] <= 1'b0;
          sync_d[gs] <= 1'b0;
        end else begin
          sync_a[gs] <= sync_raw[gs];
          sync_b[gs] <= sync_a[gs];
          sync_d[gs] <= sync_b[gs];
        end
      end
    end
  endgenerate

  logic crystal_timebase_rise, line_rise, volt_ok, volt_rise, volt_fall, ce_edge, xfer_ev;
  assign crystal_timebase_rise = sync_b[0] & ~sync_d[0];
  assign line_rise = sync_b[1] & ~sync_d[1];
  assign volt_ok = sync_b[2];
  assign volt_rise = sync_b[2] & ~sync_d[2];
  assign volt_fall = ~sync_b[2] & sync_d[2];
  assign ce_edge = sync_b[3] ^ sync_d[3];
  assign xfer_ev = sync_b[4] ^ sync_d[4];

  // Register access; serial port ignored while powered down
  logic wr_ev, rd_ev, status_read, pd_write;
  assign wr_ev = xfer_ev & xfer_write & (pwr_state != PWR_DOWN);
  assign rd_ev = xfer_ev & ~xfer_write & (pwr_state != PWR_DOWN);
  assign status_read = rd_ev & (xfer_addr == `ADDR_STATUS);
  assign pd_write = wr_ev & (xfer_addr == `ADDR_INTR_PWR_CTRL) & xfer_data[`IP_PDOWN];

  // Interrupt sources, computed below
  logic periodic_ev, alarm_ev, psense_ev, any_int, pd_exit;
  assign any_int = periodic_ev | alarm_ev | psense_ev;
  assign pd_exit = (pwr_state == PWR_DOWN) & any_int;

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      timebase_and_output_control <= `CTRL_RESET;
    end else if (wr_ev && xfer_addr == `ADDR_TIMEBASE_CTRL) begin
      timebase_and_output_control <= xfer_data;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      interrupt_and_power_control <= `CTRL_RESET;
    end else if (wr_ev && xfer_addr == `ADDR_INTR_PWR_CTRL) begin
      interrupt_and_power_control <= xfer_data;
    end else if (pd_exit || (pwr_state != PWR_RUN && volt_rise)) begin
      interrupt_and_power_control[`IP_PDOWN] <= 1'b0;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      rd_data <= 8'h00;
    end else if (rd_ev) begin
      case (xfer_addr)
        `ADDR_STATUS: rd_data <= status;
        `ADDR_TIMEBASE_CTRL: rd_data <= timebase_and_output_control;
        `ADDR_INTR_PWR_CTRL: rd_data <= interrupt_and_power_control;
        default: rd_data <= 8'h00;
      endcase
    end
  end

  logic run, tb_mains, mains_50, ps_en, alarm_en, wdog_en;
  logic [1:0] xsel;
  logic [2:0] sq_sel;
  logic [3:0] psel;
  assign run = timebase_and_output_control[`TB_RUN];
  assign tb_mains = timebase_and_output_control[`TB_SOURCE];
  assign xsel = timebase_and_output_control[`TB_XSEL_HI:`TB_XSEL_LO];
  assign mains_50 = timebase_and_output_control[`TB_MAINS_50];
  assign sq_sel = timebase_and_output_control[`TB_SQ_HI:`TB_SQ_LO];
  assign wdog_en = interrupt_and_power_control[`IP_WDOG];
  assign ps_en = interrupt_and_power_control[`IP_PSENSE];
  assign alarm_en = interrupt_and_power_control[`IP_ALARM];
  assign psel = interrupt_and_power_control[`IP_PSEL_HI:`IP_PSEL_LO];

  // Crystal prescaler to 4096 Hz, then twelve binary stages down to 1 Hz
  logic [9:0] crystal_timebase_pre, xmask;
  logic [11:0] stage, stage_fall, carry;
  logic tick_4k;

  always_comb begin
    case (xsel)
      2'h0: xmask = `XMASK_4M;
      2'h1: xmask = `XMASK_2M;
      2'h2: xmask = `XMASK_1M;
      default: xmask = `XMASK_32K;
    endcase
  end

  assign tick_4k = crystal_timebase_rise & ((crystal_timebase_pre & xmask) == xmask);

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      crystal_timebase_pre <= 10'h000;
    end else if (crystal_timebase_rise) begin
      crystal_timebase_pre <= crystal_timebase_pre + 10'h001;
    end
  end

  // A stage flips when every faster stage is high at a tick, and falls if it was high
  genvar gb;
  generate
    for (gb = 0; gb < 12; gb++) begin : g_stage
      if (gb == 0) begin : g_first
        assign carry[gb] = tick_4k;
      end else begin : g_next
        assign carry[gb] = carry[gb-1] & stage[gb-1];
      end
      assign stage_fall[gb] = carry[gb] & stage[gb];
      always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
          stage[gb] <= 1'b0;
        end else if (!run && gb >= `HALT_LO_BIT) begin
          stage[gb] <= 1'b0;
        end else if (carry[gb]) begin
          stage[gb] <= ~stage[gb];
        end
      end
    end
  endgenerate

  // Mains prescaler; power sensing disconnects its input
  logic [4:0] line_cnt, line_half;
  logic line_phase, line_ev, line_2hz, line_1hz;
  assign line_half = mains_50 ? `MAINS_HALF_50 : `MAINS_HALF_60;
  assign line_ev = line_rise & ~ps_en & run;
  assign line_2hz = line_ev & (line_cnt == line_half - 5'd1);
  assign line_1hz = line_2hz & line_phase;

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      line_cnt <= 5'h00;
      line_phase <= 1'b0;
    end else if (line_2hz) begin
      line_cnt <= 5'h00;
      line_phase <= ~line_phase;
    end else if (line_ev) begin
      line_cnt <= line_cnt + 5'h01;
    end
  end

  // Seconds update source
  logic sec_ev;
  assign sec_ev = tb_mains ? line_1hz : stage_fall[11];

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_second_tick <= 1'b0;
    end else begin
      o_second_tick <= sec_ev;
    end
  end

  // Periodic interrupt source
  always_comb begin
    case (psel)
      4'h0: periodic_ev = 1'b0;
      4'h6: periodic_ev = tb_mains ? line_ev : stage_fall[5];
      4'hB: periodic_ev = tb_mains ? line_2hz : stage_fall[10];
      4'hC: periodic_ev = sec_ev;
      4'hD: periodic_ev = i_minute_tick;
      4'hE: periodic_ev = i_hour_tick;
      4'hF: periodic_ev = i_day_tick;
      default: periodic_ev = stage_fall[psel - 4'h1];
    endcase
  end

  // Alarm delay after a gated match
  logic [12:0] alarm_cnt, alarm_dly;
  logic alarm_busy;

  always_comb begin
    case (xsel)
      2'h0: alarm_dly = 13'(`ALARM_DLY_4M_CYC);
      2'h1: alarm_dly = 13'(`ALARM_DLY_2M_CYC);
      2'h2: alarm_dly = 13'(`ALARM_DLY_1M_CYC);
      default: alarm_dly = 13'(ALARM_DLY_32K_CYC);
    endcase
  end

  assign alarm_ev = alarm_busy & (alarm_cnt == alarm_dly - 13'h0001);

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      alarm_busy <= 1'b0;
      alarm_cnt <= 13'h0000;
    end else if (alarm_ev) begin
      alarm_busy <= 1'b0;
      alarm_cnt <= 13'h0000;
    end else if (alarm_busy) begin
      alarm_cnt <= alarm_cnt + 13'h0001;
    end else if (i_alarm_match && alarm_en) begin
      alarm_busy <= 1'b1;
    end
  end

  // Power sense: line transitions that stop for the window flag one failure per arming
  logic [19:0] quiet_cnt;
  logic ps_armed, ps_en_d;
  assign psense_ev = ps_en & ps_armed & (quiet_cnt == 20'(PSENSE_DLY_CYC - 1));

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      quiet_cnt <= 20'h00000;
      ps_armed <= 1'b0;
      ps_en_d <= 1'b0;
    end else begin
      ps_en_d <= ps_en;
      if (ps_en && !ps_en_d) begin
        ps_armed <= 1'b1;
      end else if (psense_ev) begin
        ps_armed <= 1'b0;
      end
      if (line_rise || !ps_en || !ps_armed) begin
        quiet_cnt <= 20'h00000;
      end else begin
        quiet_cnt <= quiet_cnt + 20'h00001;
      end
    end
  end

  // Watchdog: two 64 Hz or mains ticks without a chip-select edge
  logic [1:0] wdog_ticks;
  logic [4:0] wdog_pulse;
  logic wdog_tick, wdog_fire;
  assign wdog_tick = tb_mains ? line_rise : stage_fall[5];
  assign wdog_fire = wdog_en & wdog_tick & (wdog_ticks == `WDOG_TIMEOUT_TICKS - 2'd1);

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      wdog_ticks <= 2'h0;
      wdog_pulse <= 5'h00;
    end else begin
      if (!wdog_en || ce_edge || wdog_fire) begin
        wdog_ticks <= 2'h0;
      end else if (wdog_tick) begin
        wdog_ticks <= wdog_ticks + 2'h1;
      end
      if (wdog_fire) begin
        wdog_pulse <= `WDOG_PULSE_CYC;
      end else if (wdog_pulse != 5'h00) begin
        wdog_pulse <= wdog_pulse - 5'h01;
      end
    end
  end

  // Status: hardware sets win over the clearing read
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      status <= `STATUS_RESET;
    end else begin
      if (status_read) begin
        status[`ST_WDOG] <= 1'b0;
        status[`ST_FIRST_UP] <= 1'b0;
        status[`ST_INT_TRUE] <= 1'b0;
        status[`ST_ALARM] <= 1'b0;
        status[`ST_PERIODIC] <= 1'b0;
      end
      status[7] <= 1'b0;
      status[`ST_TEST] <= 1'b0;
      if (wdog_fire) status[`ST_WDOG] <= 1'b1;
      if (psense_ev) status[`ST_PSENSE] <= 1'b1;
      if (alarm_ev) status[`ST_ALARM] <= 1'b1;
      if (periodic_ev) status[`ST_PERIODIC] <= 1'b1;
      if (any_int) status[`ST_INT_TRUE] <= 1'b1;
    end
  end

  // Interrupt line held low from any source until status is read
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_irq_n_drive_low <= 1'b0;
    end else if (any_int) begin
      o_irq_n_drive_low <= 1'b1;
    end else if (status_read) begin
      o_irq_n_drive_low <= 1'b0;
    end
  end

  // Supply mode is caught once the voltage sense has settled after reset
  logic [1:0] por_cnt;
  logic por_done, battery_mode;

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      por_cnt <= 2'h0;
      por_done <= 1'b0;
      battery_mode <= 1'b0;
    end else if (!por_done) begin
      por_cnt <= por_cnt + 2'h1;
      if (por_cnt == `POR_SETTLE_CYC - 2'd1) begin
        por_done <= 1'b1;
        battery_mode <= ~volt_ok;
      end
    end
  end

  // Power state
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      pwr_state <= PWR_LOW;
    end else if (!por_done) begin
      pwr_state <= PWR_LOW;
    end else begin
      case (pwr_state)
        PWR_RUN: begin
          if (pd_write) begin
            pwr_state <= PWR_DOWN;
          end else if (!volt_ok) begin
            pwr_state <= PWR_LOW;
          end
        end
        PWR_DOWN: begin
          if (pd_exit) begin
            pwr_state <= PWR_RUN;
          end else if (volt_fall) begin
            pwr_state <= PWR_LOW;
          end
        end
        PWR_LOW: begin
          if (volt_ok && (volt_rise || por_cnt == `POR_SETTLE_CYC)) begin
            pwr_state <= PWR_RUN;
          end
        end
        default: pwr_state <= PWR_LOW;
      endcase
    end
  end

  // Supply enable follows the power state, and any interrupt outside the low-voltage state raises it unless a power-down write comes in the same cycle
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_supply_enable_out <= 1'b0;
    end else if (pd_write) begin
      o_supply_enable_out <= 1'b0;
    end else if (any_int && pwr_state != PWR_LOW) begin
      o_supply_enable_out <= 1'b1;
    end else if (pwr_state == PWR_LOW && volt_ok && (volt_rise || !battery_mode)) begin
      o_supply_enable_out <= por_done;
    end else if (pwr_state == PWR_LOW && battery_mode) begin
      o_supply_enable_out <= 1'b0;
    end
  end

  // Host reset held while not running or during a watchdog pulse
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_host_reset_out_n_drive_low <= 1'b1;
    end else begin
      o_host_reset_out_n_drive_low <= (pwr_state != PWR_RUN) | (wdog_pulse != 5'h00) | wdog_fire;
    end
  end

  // Square output; the 2 Hz mains case is 12 of 25 high on 50 Hz, the only uneven duty
  logic sq_next;
  always_comb begin
    case (sq_sel)
      3'h0: sq_next = sync_b[0];
      3'h1: sq_next = crystal_timebase_pre[0];
      3'h2: sq_next = crystal_timebase_pre[1];
      3'h3: sq_next = crystal_timebase_pre[2];
      3'h4: sq_next = 1'b0;
      3'h5: sq_next = tb_mains ? line_phase : stage[11];
      3'h6: sq_next = tb_mains ? (line_cnt < {1'b0, line_half[4:1]}) : stage[10];
      default: sq_next = sync_b[1];
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_square_out <= 1'b0;
    end else begin
      o_square_out <= sq_next & (pwr_state == PWR_RUN);
    end
  end

endmodule

// ### src/rtc_ctl_map.svh
// Register offsets, field positions, reset values and timing counts of the
// clock-control block. Assumes a 200 MHz system clock.
`ifndef RTC_CTL_MAP_SVH
`define RTC_CTL_MAP_SVH

// Register addresses (low six bits of the address/control byte)
`define ADDR_STATUS 6'h30
`define ADDR_TIMEBASE_CTRL 6'h31
`define ADDR_INTR_PWR_CTRL 6'h32
`define ADDR_BYTE_WRITE 7
`define ADDR_BYTE_CLOCK 5

// Timebase and output control fields
`define TB_RUN 7
`define TB_SOURCE 6
`define TB_XSEL_HI 5
`define TB_XSEL_LO 4
`define TB_MAINS_50 3
`define TB_SQ_HI 2
`define TB_SQ_LO 0

// Interrupt and power control fields
`define IP_WDOG 7
`define IP_PDOWN 6
`define IP_PSENSE 5
`define IP_ALARM 4
`define IP_PSEL_HI 3
`define IP_PSEL_LO 0

// Status fields
`define ST_WDOG 6
`define ST_TEST 5
`define ST_FIRST_UP 4
`define ST_INT_TRUE 3
`define ST_PSENSE 2
`define ST_ALARM 1
`define ST_PERIODIC 0

// Reset values
`define CTRL_RESET 8'h00
`define STATUS_RESET 8'h10

// Crystal divider: masks that give a 4096 Hz tick for each crystal choice
`define XMASK_4M 10'h3FF
`define XMASK_2M 10'h1FF
`define XMASK_1M 10'h0FF
`define XMASK_32K 10'h007
`define HALT_LO_BIT 6

// Mains prescaler: line cycles per half second
`define MAINS_HALF_50 5'd25
`define MAINS_HALF_60 5'd30

// Timing
`define CLK_MHZ 200
`define ALARM_DLY_32K_NS 30500
`define ALARM_DLY_2M_NS 15300
`define ALARM_DLY_1M_NS 15300
`define ALARM_DLY_4M_NS 7600
`define ALARM_DLY_32K_CYC ((`ALARM_DLY_32K_NS * `CLK_MHZ) / 1000)
`define ALARM_DLY_2M_CYC ((`ALARM_DLY_2M_NS * `CLK_MHZ) / 1000)
`define ALARM_DLY_1M_CYC ((`ALARM_DLY_1M_NS * `CLK_MHZ) / 1000)
`define ALARM_DLY_4M_CYC ((`ALARM_DLY_4M_NS * `CLK_MHZ) / 1000)
`define PSENSE_DLY_NS 2680000
`define PSENSE_DLY_CYC ((`PSENSE_DLY_NS / 1000) * `CLK_MHZ)
`define WDOG_TIMEOUT_TICKS 2'd2
`define WDOG_PULSE_CYC 5'd16
`define POR_SETTLE_CYC 2'd3

`endif

// ### src/rtc_ctl_pkg.sv
// Types shared by the clock-control block and its serial port.
// Constants live in rtc_ctl_map.svh.
package rtc_ctl_pkg;

  typedef logic [7:0] reg_byte_t;

  // Supply state: running, powered down by software, or system voltage low
  typedef enum logic [1:0] {
    PWR_RUN,
    PWR_DOWN,
    PWR_LOW
  } pwr_state_e;

endpackage

// ### src/rtc_serial_port.sv
// Serial register port on the host's shift clock.
// Assumes chip-select low resets the link logic and the clock stands while it is low.
`timescale 1ns/100ps
module rtc_serial_port
  import rtc_ctl_pkg::*;
(
  // Link pins
  input wire logic i_spi_sck,
  input wire logic i_spi_ce,
  input wire logic i_spi_mosi,
  output logic o_spi_miso,
  output logic o_spi_miso_oe,
  // System side
  input wire logic i_sys_rst,
  input wire reg_byte_t i_rd_data,
  output logic o_xfer_toggle,
  output logic o_xfer_write,
  output logic [5:0] o_xfer_addr,
  output reg_byte_t o_xfer_data
);

  logic [2:0] bit_cnt;
  logic [6:0] in_sr;
  logic have_addr;
  logic have_data;
  reg_byte_t out_sr;
  reg_byte_t next_byte;

  assign next_byte = {in_sr, i_spi_mosi};

  // Chip-select low holds the link logic in reset
  always_ff @(posedge i_spi_sck or negedge i_spi_ce) begin
    if (!i_spi_ce) begin
      bit_cnt <= 3'h0;
      in_sr <= 7'h00;
      have_addr <= 1'b0;
      have_data <= 1'b0;
      o_xfer_write <= 1'b0;
      o_xfer_addr <= 6'h00;
      o_xfer_data <= 8'h00;
    end else begin
      bit_cnt <= bit_cnt + 3'h1;
      in_sr <= next_byte[6:0];
      if (bit_cnt == 3'h7) begin
        if (!have_addr) begin
          have_addr <= 1'b1;
          o_xfer_write <= next_byte[`ADDR_BYTE_WRITE];
          o_xfer_addr <= next_byte[5:0];
        end else if (o_xfer_write) begin
          // Step before later write bytes, so the address travels with its own data
          o_xfer_data <= next_byte;
          have_data <= 1'b1;
          if (have_data) begin
            o_xfer_addr <= {o_xfer_addr[5], 5'(o_xfer_addr[4:0] + 5'h01)};
          end
        end else begin
          o_xfer_addr <= {o_xfer_addr[5], 5'(o_xfer_addr[4:0] + 5'h01)};
        end
      end
    end
  end

  // The toggle survives chip-select so a frame end is never seen as an event
  always_ff @(posedge i_spi_sck or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_xfer_toggle <= 1'b0;
    end else if (i_spi_ce && bit_cnt == 3'h7) begin
      if (have_addr || !next_byte[`ADDR_BYTE_WRITE]) begin
        o_xfer_toggle <= ~o_xfer_toggle;
      end
    end
  end

  // Read data leaves on the opposite edge, MSB first
  always_ff @(negedge i_spi_sck or negedge i_spi_ce) begin
    if (!i_spi_ce) begin
      out_sr <= 8'h00;
      o_spi_miso <= 1'b0;
      o_spi_miso_oe <= 1'b0;
    end else if (have_addr && !o_xfer_write) begin
      o_spi_miso_oe <= 1'b1;
      if (bit_cnt == 3'h0) begin
        out_sr <= {i_rd_data[6:0], 1'b0};
        o_spi_miso <= i_rd_data[7];
      end else begin
        out_sr <= {out_sr[6:0], 1'b0};
        o_spi_miso <= out_sr[7];
      end
    end
  end

endmodule

// ### bench/rtc_ctl_checker.sv
// Port assertions for the clock-control core.
// Assumes system voltage is good around reset release.
`timescale 1ns/100ps
module rtc_ctl_checker (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_spi_ce,
  input wire logic i_sys_volt_ok,
  input wire logic o_spi_miso_oe,
  input wire logic o_square_out,
  input wire logic o_supply_enable_out,
  input wire logic o_irq_n_drive_low,
  input wire logic o_host_reset_out_n_drive_low
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);
  a_irq_holds_idle: assert property ((!i_spi_ce)[*8] ##0 o_irq_n_drive_low |=> o_irq_n_drive_low)
    else $error("interrupt released without status read");
  a_ce_low_quiet: assert property ((!i_spi_ce)[*2] |-> !o_spi_miso_oe)
    else $error("data out driven while deselected");
  a_por_supply_up: assert property ($fell(i_sys_rst) && i_sys_volt_ok |-> !o_supply_enable_out ##[2:7] o_supply_enable_out)
    else $error("supply enable not raised after reset");
  a_por_irq_clear: assert property ($fell(i_sys_rst) |-> (!o_irq_n_drive_low)[*3])
    else $error("interrupt active after reset");
  a_irq_wakes_up: assert property ($rose(o_irq_n_drive_low) && i_sys_volt_ok |-> ##[0:3] o_supply_enable_out)
    else $error("interrupt did not restore supply");
  a_down_square_low: assert property ($fell(o_supply_enable_out) |-> ##[0:2] (!o_square_out)[*4])
    else $error("square output runs while down");
  a_down_host_rst: assert property ($fell(o_supply_enable_out) && i_sys_volt_ok |-> ##[0:2] o_host_reset_out_n_drive_low)
    else $error("no host reset on power-down");
  a_up_host_free: assert property ($rose(o_supply_enable_out) |-> ##[0:3] !o_host_reset_out_n_drive_low)
    else $error("host reset held after power-up");
endmodule
bind rtc_ctl_core rtc_ctl_checker rtc_ctl_checker_inst (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_spi_ce(i_spi_ce),
  .i_sys_volt_ok(i_sys_volt_ok), .o_spi_miso_oe(o_spi_miso_oe), .o_square_out(o_square_out),
  .o_supply_enable_out(o_supply_enable_out), .o_irq_n_drive_low(o_irq_n_drive_low),
  .o_host_reset_out_n_drive_low(o_host_reset_out_n_drive_low));

// ### bench/rtc_spi_host.sv
// Host model for the serial register port, 6 ns shift clock.
// Assumes one frame at a time; clock stands low outside frames.
`timescale 1ns/100ps
module rtc_spi_host (
  output logic o_sck,
  output logic o_ce,
  output logic o_mosi,
  input wire logic i_miso
);
  initial begin
    o_sck = 1'b0;
    o_ce = 1'b0;
    o_mosi = 1'b0;
  end
  // Long high phase after each byte gives the core its read turn-around
  task automatic shift(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      o_mosi = tx[i];
      #3 o_sck = 1'b1;
      rx[i] = i_miso;
      #3;
      if (i == 0) #48;
      o_sck = 1'b0;
    end
  endtask
  task automatic frame(input logic [7:0] ctl, input logic [7:0] tx, output logic [7:0] rx);
    logic [7:0] junk;
    #1.3 o_ce = 1'b1;
    #6 shift(ctl, junk);
    shift(tx, rx);
    #6 o_ce = 1'b0;
    o_mosi = ~o_mosi;
  endtask
endmodule

// ### bench/tb_top.sv
// Self-checking bench for the clock-control core.
// Assumes shortened delay parameters; mains moves only in the watchdog test.
`timescale 1ns/100ps
module tb_top;
  import rtc_ctl_pkg::*;
  localparam int ALARM_CYC = 40;
  localparam int SENSE_CYC = 200;
  typedef struct packed {logic wr; logic [5:0] addr; reg_byte_t data; reg_byte_t exp;} row_s;
  row_s rows [10] = '{'{1'b0, 6'h30, 8'h00, 8'h10}, '{1'b0, 6'h30, 8'h00, 8'h00}, '{1'b0, 6'h31, 8'h00, 8'h00},
    '{1'b0, 6'h32, 8'h00, 8'h00}, '{1'b1, 6'h31, 8'hB0, 8'h00}, '{1'b0, 6'h31, 8'h00, 8'hB0},
    '{1'b1, 6'h3F, 8'h55, 8'h00}, '{1'b0, 6'h3F, 8'h00, 8'h00}, '{1'b1, 6'h32, 8'h10, 8'h00},
    '{1'b0, 6'h32, 8'h00, 8'h10}};
  logic i_clock = 1'b0;
  logic i_sys_rst = 1'b0;
  logic i_sys_volt_ok = 1'b1;
  logic i_alarm_match = 1'b0;
  logic i_mains_line = 1'b0;
  logic [5:0] crystal_timebase_cnt = 6'h00;
  logic sck, ce, mosi, miso, sq, sup, irq, hrst;
  int errors = 0;
  int compares = 0;
  int cycles = 0;
  reg_byte_t rd;
  always #2.5 i_clock = ~i_clock;
  always @(posedge i_clock) begin
    crystal_timebase_cnt <= crystal_timebase_cnt + 6'h01;
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      errors++;
      end_of_test();
    end
  end
  rtc_ctl_core #(.ALARM_DLY_32K_CYC(ALARM_CYC), .PSENSE_DLY_CYC(SENSE_CYC)) rtc_ctl_core_inst (
    .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_spi_sck(sck), .i_spi_ce(ce), .i_spi_mosi(mosi),
    .o_spi_miso(miso), .o_spi_miso_oe(), .i_crystal_timebase(crystal_timebase_cnt[5]), .i_mains_line(i_mains_line),
    .i_sys_volt_ok(i_sys_volt_ok), .i_alarm_match(i_alarm_match), .i_minute_tick(1'b0), .i_hour_tick(1'b0),
    .i_day_tick(1'b0), .o_second_tick(), .o_square_out(sq), .o_supply_enable_out(sup),
    .o_irq_n_drive_low(irq), .o_host_reset_out_n_drive_low(hrst));
  rtc_spi_host rtc_spi_host_inst (.o_sck(sck), .o_ce(ce), .o_mosi(mosi), .i_miso(miso));
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic pause(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask
  task automatic reg_rw(input logic wr, input logic [5:0] addr, input reg_byte_t wdata);
    rtc_spi_host_inst.frame({wr, 1'b0, addr}, wdata, rd);
    pause(8);
  endtask
  task automatic end_of_test();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    // Raised by a nonblocking write at time zero so the link toggle's asynchronous reset sees an edge
    i_sys_rst <= 1'b1;
    repeat (16) @(posedge i_clock);
    i_sys_rst <= 1'b0;
    pause(12);
    check(sup, 1'b1);
    foreach (rows[k]) begin
      reg_rw(rows[k].wr, rows[k].addr, rows[k].data);
      if (!rows[k].wr) check(rd, rows[k].exp);
    end
    @(posedge i_clock) i_alarm_match <= 1'b1;
    @(posedge i_clock) i_alarm_match <= 1'b0;
    pause(ALARM_CYC - 4);
    check(irq, 1'b0);
    pause(8);
    check(irq, 1'b1);
    pause(10);
    check(irq, 1'b1);
    reg_rw(1'b0, 6'h30, 8'h00);
    check(rd, 8'h0A);
    check(irq, 1'b0);
    // Crystal timebase is already selected, so sensing may be armed
    reg_rw(1'b1, 6'h32, 8'h20);
    pause(SENSE_CYC + 20);
    check(irq, 1'b1);
    reg_rw(1'b0, 6'h30, 8'h00);
    check(rd, 8'h0C);
    reg_rw(1'b0, 6'h30, 8'h00);
    check(rd, 8'h04);
    reg_rw(1'b1, 6'h32, 8'h40);
    check({sup, sq, hrst}, 8'h01);
    @(posedge i_clock) i_sys_volt_ok <= 1'b0;
    pause(10);
    i_sys_volt_ok <= 1'b1;
    pause(12);
    check({sup, hrst}, 8'h02);
    reg_rw(1'b0, 6'h32, 8'h00);
    check(rd, 8'h00);
    // Watchdog on the mains timebase: two line rises with chip-select standing still
    reg_rw(1'b1, 6'h31, 8'hC0);
    reg_rw(1'b1, 6'h32, 8'h80);
    repeat (2) begin
      @(posedge i_clock) i_mains_line <= 1'b1;
      repeat (4) @(posedge i_clock);
      i_mains_line <= 1'b0;
      repeat (4) @(posedge i_clock);
    end
    pause(1);
    check(hrst, 1'b1);
    pause(30);
    check(hrst, 1'b0);
    reg_rw(1'b0, 6'h30, 8'h00);
    check(rd, 8'h44);
    // Reset in mid-run: first-time-up returns and the power-sense flag goes
    @(posedge i_clock) i_sys_rst <= 1'b1;
    repeat (3) @(posedge i_clock);
    i_sys_rst <= 1'b0;
    pause(12);
    reg_rw(1'b0, 6'h30, 8'h00);
    check(rd, 8'h10);
    end_of_test();
  end
endmodule
